//--- bertc_regs.svh
// register offsets, field positions, reset values and counts of the bit error rate tester
`ifndef BERTC_REGS_SVH
`define BERTC_REGS_SVH

`define BERTC_OFF_CTRL 8'h80
`define BERTC_OFF_CFG_LO 8'h82
`define BERTC_OFF_CFG_HI 8'h83
`define BERTC_OFF_SEED0 8'h84
`define BERTC_OFF_SEED3 8'h87
`define BERTC_OFF_STATUS 8'h8c
`define BERTC_OFF_ERR0 8'h94
`define BERTC_OFF_ERR3 8'h97

`define BERTC_CTRL_MON 6
`define BERTC_CTRL_RXLD 5
`define BERTC_CTRL_RXINV 4
`define BERTC_CTRL_RESYNC 3
`define BERTC_CTRL_ARD 2
`define BERTC_CTRL_TXLD 1
`define BERTC_CTRL_TXINV 0
`define BERTC_CFG_QUASI_RANDOM_SELECT 6
`define BERTC_CFG_REP 5
`define BERTC_STAT_DONE 3
`define BERTC_STAT_BEC 1
`define BERTC_STAT_OOS 0

`define BERTC_CTRL_RST 7'h00
`define BERTC_CFG_LO_RST 7'h00
`define BERTC_CFG_HI_RST 5'h00
`define BERTC_SEED_RST 32'h00000000

`define BERTC_SYNC_LAST 6'h1f
`define BERTC_WIN_LAST 6'h3f
`define BERTC_WIN_ERR_LAST 3'h5
`define BERTC_QUASI_RANDOM_SELECT_ZRUN 4'he
`define BERTC_QUASI_RANDOM_SELECT_LEN 5'h13
`define BERTC_QUASI_RANDOM_SELECT_TAP 5'h10

`endif

//--- bertc_pkg.sv
// types shared by the bit error rate tester modules
package bertc_pkg;
   typedef logic [7:0] bertc_byte_t;
   typedef enum {CHK_HUNT, CHK_LOCK} bertc_chk_e;
   typedef struct packed {
      logic quasi_random_select;
      logic rep;
      logic [4:0] len;
      logic [4:0] tap;
      logic [31:0] seed;
   } bertc_cfg_s;
endpackage : bertc_pkg

//--- bertc_cfg_if.sv
// programmed pattern configuration carried from the register file to the generators
interface bertc_cfg_if;
   import bertc_pkg::*;
   bertc_cfg_s cfg;
   modport src (output cfg);
   modport dst (input cfg);
endinterface : bertc_cfg_if

//--- bertc_sync.sv
// two flip-flop synchroniser for signals from outside the system clock domain
module bertc_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // asynchronous in, synchronised out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   if (W < 1)
   begin : g_bad_width
      $error("W must be at least one");
   end

   logic [W-1:0] meta;

   // meta feeds q and nothing else
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         meta <= '0;
         q <= '0;
      end
      else
      begin
         meta <= d;
         q <= meta;
      end
   end
endmodule : bertc_sync

//--- bertc_gen.sv
// two-tap polynomial or repetitive pattern generator, optionally tracking an input stream
`include "bertc_regs.svh"
module bertc_gen (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // programmed configuration
   bertc_cfg_if.dst cfg_port,
   // control
   input wire logic load,
   input wire logic step,
   input wire logic track,
   input wire logic track_bit,
   // next pattern bit
   output logic pred
);
   import bertc_pkg::*;

   logic [31:0] state;
   logic [3:0] zrun;
   logic quasi_random_select;
   logic rep;
   logic [4:0] len;
   logic [4:0] tap;
   logic [31:0] next_state;
   logic [3:0] next_zrun;
   logic next_quasi_random_select;
   logic next_rep;
   logic [4:0] next_len;
   logic [4:0] next_tap;
   logic [4:0] len_i;
   logic [4:0] tap_i;
   logic nb;
   logic in_bit;

   always_comb
   begin
      len_i = quasi_random_select ? `BERTC_QUASI_RANDOM_SELECT_LEN : len;
      tap_i = quasi_random_select ? `BERTC_QUASI_RANDOM_SELECT_TAP : tap;
      // repetitive feeds back stage n alone, polynomial adds the tap stage
      nb = (rep && !quasi_random_select) ? state[len_i] : (state[len_i] ^ state[tap_i]);
      pred = (quasi_random_select && zrun == `BERTC_QUASI_RANDOM_SELECT_ZRUN) ? 1'b1 : nb;
      in_bit = track ? track_bit : pred;
      next_state = state;
      next_zrun = zrun;
      next_quasi_random_select = quasi_random_select;
      next_rep = rep;
      next_len = len;
      next_tap = tap;
      if (load)
      begin
         next_state = cfg_port.cfg.seed;
         next_zrun = 4'h0;
         next_quasi_random_select = cfg_port.cfg.quasi_random_select;
         next_rep = cfg_port.cfg.rep;
         next_len = cfg_port.cfg.len;
         next_tap = cfg_port.cfg.tap;
      end
      else if (step)
      begin
         next_state = {state[30:0], in_bit};
         if (in_bit)
            next_zrun = 4'h0;
         else if (zrun != `BERTC_QUASI_RANDOM_SELECT_ZRUN)
            next_zrun = zrun + 4'h1;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         state <= 32'h00000000;
         zrun <= 4'h0;
         quasi_random_select <= 1'b0;
         rep <= 1'b0;
         len <= 5'h00;
         tap <= 5'h00;
      end
      else
      begin
         state <= next_state;
         zrun <= next_zrun;
         quasi_random_select <= next_quasi_random_select;
         rep <= next_rep;
         len <= next_len;
         tap <= next_tap;
      end
   end

   a_gen_seed_load: assert property (@(posedge clk_sys) disable iff (rst)
      load |=> state == $past(cfg_port.cfg.seed))
      else $error("generator did not take the seed on load");
   a_gen_shift_bit: assert property (@(posedge clk_sys) disable iff (rst)
      (step && !load) |=> (state[31:1] == $past(state[30:0])) && state[0] == $past(in_bit))
      else $error("generator did not shift in one bit per step");
endmodule : bertc_gen

//--- bertc_top.sv
// bit error rate tester: registers, command edges, transmit generator and receive checker
//
// The implementer's own choice: strobed register access.
`include "bertc_regs.svh"
module bertc_top #(
   parameter int ERR_W = 32
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // register port
   input wire bertc_pkg::bertc_byte_t addr,
   input wire bertc_pkg::bertc_byte_t wdata,
   input wire logic wr,
   input wire logic rd,
   output bertc_pkg::bertc_byte_t rdata,
   // serial line
   input wire logic tx_line_clock,
   input wire logic rx_line_clock,
   input wire logic rx_data,
   output logic tx_data
);
   import bertc_pkg::*;

   if (ERR_W < 8 || ERR_W > 32)
   begin : g_bad_width
      $error("ERR_W must lie between 8 and 32");
   end

   // line signals: clocks are sampled, their rising edges become steps
   logic ls_tx_clk;
   logic ls_rx_clk;
   logic ls_rx_bit;
   logic tx_clk_prev;
   logic rx_clk_prev;
   logic tx_step;
   logic rx_step;

   bertc_sync #(.W(3)) u_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .d({tx_line_clock, rx_line_clock, rx_data}),
      .q({ls_tx_clk, ls_rx_clk, ls_rx_bit})
   );

   assign tx_step = ls_tx_clk && !tx_clk_prev;
   assign rx_step = ls_rx_clk && !rx_clk_prev;

   // software registers
   logic [6:0] ctrl;
   logic [6:0] ctrl_prev;
   logic [6:0] cfg_lo;
   logic [4:0] cfg_hi;
   logic [31:0] seed;
   logic [6:0] next_ctrl;
   logic [6:0] next_cfg_lo;
   logic [4:0] next_cfg_hi;
   logic [31:0] next_seed;
   logic [6:0] rise;

   always_comb
   begin
      next_ctrl = ctrl;
      next_cfg_lo = cfg_lo;
      next_cfg_hi = cfg_hi;
      next_seed = seed;
      if (wr)
      begin
         case (addr)
            // bit seven is kept at zero by software and not stored
            `BERTC_OFF_CTRL: next_ctrl = wdata[6:0];
            `BERTC_OFF_CFG_LO: next_cfg_lo = wdata[6:0];
            `BERTC_OFF_CFG_HI: next_cfg_hi = wdata[4:0];
            default:
            begin
               if (addr >= `BERTC_OFF_SEED0 && addr <= `BERTC_OFF_SEED3)
                  next_seed[8*addr[1:0] +: 8] = wdata;
            end
         endcase
      end
   end

   assign rise = ctrl & ~ctrl_prev;

   // configuration is sampled at the load step; it must hold still until then
   bertc_cfg_if u_cfg ();
   assign u_cfg.cfg = '{quasi_random_select: cfg_lo[`BERTC_CFG_QUASI_RANDOM_SELECT], rep: cfg_lo[`BERTC_CFG_REP],
                        len: cfg_lo[4:0], tap: cfg_hi, seed: seed};

   // command edges held pending until the line clock of their side ticks
   logic tx_ld_pend;
   logic rx_ld_pend;
   logic rs_pend;
   logic mon_pend;
   logic next_tx_ld_pend;
   logic next_rx_ld_pend;
   logic next_rs_pend;
   logic next_mon_pend;
   logic tx_ld_fire;
   logic rx_ld_fire;
   logic rs_fire;
   logic mon_fire;

   always_comb
   begin
      tx_ld_fire = tx_ld_pend && tx_step;
      rx_ld_fire = rx_ld_pend && rx_step;
      rs_fire = rs_pend && rx_step;
      mon_fire = mon_pend && rx_step;
      // a new edge wins over the step that consumes the old one
      next_tx_ld_pend = rise[`BERTC_CTRL_TXLD] || (tx_ld_pend && !tx_step);
      next_rx_ld_pend = rise[`BERTC_CTRL_RXLD] || (rx_ld_pend && !rx_step);
      next_rs_pend = rise[`BERTC_CTRL_RESYNC] || (rs_pend && !rx_step);
      next_mon_pend = rise[`BERTC_CTRL_MON] || (mon_pend && !rx_step);
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         ctrl <= `BERTC_CTRL_RST;
         ctrl_prev <= `BERTC_CTRL_RST;
         cfg_lo <= `BERTC_CFG_LO_RST;
         cfg_hi <= `BERTC_CFG_HI_RST;
         seed <= `BERTC_SEED_RST;
         tx_clk_prev <= 1'b0;
         rx_clk_prev <= 1'b0;
         tx_ld_pend <= 1'b0;
         rx_ld_pend <= 1'b0;
         rs_pend <= 1'b0;
         mon_pend <= 1'b0;
      end
      else
      begin
         ctrl <= next_ctrl;
         ctrl_prev <= ctrl;
         cfg_lo <= next_cfg_lo;
         cfg_hi <= next_cfg_hi;
         seed <= next_seed;
         tx_clk_prev <= ls_tx_clk;
         rx_clk_prev <= ls_rx_clk;
         tx_ld_pend <= next_tx_ld_pend;
         rx_ld_pend <= next_rx_ld_pend;
         rs_pend <= next_rs_pend;
         mon_pend <= next_mon_pend;
      end
   end

   // generators
   logic tx_pred;
   logic rx_pred;
   logic rx_in;
   bertc_chk_e chk;

   assign rx_in = ls_rx_bit ^ ctrl[`BERTC_CTRL_RXINV];

   bertc_gen u_tx_gen (
      .clk_sys(clk_sys),
      .rst(rst),
      .cfg_port(u_cfg.dst),
      .load(tx_ld_fire),
      .step(tx_step),
      .track(1'b0),
      .track_bit(1'b0),
      .pred(tx_pred)
   );

   // while hunting, the receiver shifts in the incoming stream to find the phase
   bertc_gen u_rx_gen (
      .clk_sys(clk_sys),
      .rst(rst),
      .cfg_port(u_cfg.dst),
      .load(rx_ld_fire),
      .step(rx_step),
      .track(chk == CHK_HUNT),
      .track_bit(rx_in),
      .pred(rx_pred)
   );

   // receive checker and counters
   logic [5:0] match_cnt;
   logic [5:0] win_cnt;
   logic [2:0] win_err;
   logic [ERR_W-1:0] err_cnt;
   logic [ERR_W-1:0] perf;
   logic done;
   logic mism;
   bertc_chk_e next_chk;
   logic [5:0] next_match_cnt;
   logic [5:0] next_win_cnt;
   logic [2:0] next_win_err;
   logic [ERR_W-1:0] next_err_cnt;
   logic [ERR_W-1:0] next_perf;
   logic next_done;
   logic bit_err;

   always_comb
   begin
      mism = rx_step && (rx_in != rx_pred);
      bit_err = mism && chk == CHK_LOCK;
      next_chk = chk;
      next_match_cnt = match_cnt;
      next_win_cnt = win_cnt;
      next_win_err = win_err;
      if (rx_ld_fire || rs_fire)
      begin
         next_chk = CHK_HUNT;
         next_match_cnt = 6'h00;
      end
      else if (rx_step)
      begin
         case (chk)
            CHK_HUNT:
            begin
               if (mism)
                  next_match_cnt = 6'h00;
               else if (match_cnt == `BERTC_SYNC_LAST)
               begin
                  next_chk = CHK_LOCK;
                  next_win_cnt = 6'h00;
                  next_win_err = 3'h0;
               end
               else
                  next_match_cnt = match_cnt + 6'h01;
            end
            CHK_LOCK:
            begin
               next_win_cnt = win_cnt + 6'h01;
               if (win_cnt == `BERTC_WIN_LAST)
                  next_win_err = {2'h0, mism};
               else if (mism)
                  next_win_err = win_err + 3'h1;
               // the disable bit only stops leaving lock on its own
               if (mism && win_err == `BERTC_WIN_ERR_LAST && !ctrl[`BERTC_CTRL_ARD])
               begin
                  next_chk = CHK_HUNT;
                  next_match_cnt = 6'h00;
               end
            end
            default: next_chk = CHK_HUNT;
         endcase
      end
      // restart to zero, or one when an error lands on the update step
      if (mon_fire)
         next_err_cnt = {{(ERR_W-1){1'b0}}, bit_err};
      else if (bit_err && err_cnt != {ERR_W{1'b1}})
         next_err_cnt = err_cnt + {{(ERR_W-1){1'b0}}, 1'b1};
      else
         next_err_cnt = err_cnt;
      next_perf = mon_fire ? err_cnt : perf;
      // done falls as soon as the request bit is low
      next_done = ctrl[`BERTC_CTRL_MON] && (done || mon_fire);
   end

   // transmit output and read data
   logic next_tx_data;
   bertc_byte_t next_rdata;
   logic [31:0] perf32;

   assign perf32 = 32'(perf);

   always_comb
   begin
      next_tx_data = tx_step ? (tx_pred ^ ctrl[`BERTC_CTRL_TXINV]) : tx_data;
      next_rdata = 8'h00;
      if (rd)
      begin
         case (addr)
            `BERTC_OFF_CTRL: next_rdata = {1'b0, ctrl};
            `BERTC_OFF_CFG_LO: next_rdata = {1'b0, cfg_lo};
            `BERTC_OFF_CFG_HI: next_rdata = {3'h0, cfg_hi};
            `BERTC_OFF_STATUS: next_rdata = {4'h0, done, 1'b0, err_cnt != '0, chk == CHK_HUNT};
            default:
            begin
               if (addr >= `BERTC_OFF_SEED0 && addr <= `BERTC_OFF_SEED3)
                  next_rdata = seed[8*addr[1:0] +: 8];
               else if (addr >= `BERTC_OFF_ERR0 && addr <= `BERTC_OFF_ERR3)
                  next_rdata = perf32[8*addr[1:0] +: 8];
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         chk <= CHK_HUNT;
         match_cnt <= 6'h00;
         win_cnt <= 6'h00;
         win_err <= 3'h0;
         err_cnt <= '0;
         perf <= '0;
         done <= 1'b0;
         tx_data <= 1'b0;
         rdata <= 8'h00;
      end
      else
      begin
         chk <= next_chk;
         match_cnt <= next_match_cnt;
         win_cnt <= next_win_cnt;
         win_err <= next_win_err;
         err_cnt <= next_err_cnt;
         perf <= next_perf;
         done <= next_done;
         tx_data <= next_tx_data;
         rdata <= next_rdata;
      end
   end

   a_rx_load_oos: assert property (@(posedge clk_sys) disable iff (rst)
      rx_ld_fire |=> chk == CHK_HUNT && match_cnt == 6'h00)
      else $error("receive load left checker in lock");
   a_manual_resync_oos: assert property (@(posedge clk_sys) disable iff (rst)
      (rs_pend && rx_step) |=> chk == CHK_HUNT)
      else $error("manual resync left checker in lock");
   a_edge_pending: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(ctrl[`BERTC_CTRL_RXLD]) |=> rx_ld_pend)
      else $error("receive load edge not held for the line clock");
   a_done_clear: assert property (@(posedge clk_sys) disable iff (rst)
      !ctrl[`BERTC_CTRL_MON] |=> !done)
      else $error("update done stayed high with request low");
   a_perf_copy: assert property (@(posedge clk_sys) disable iff (rst)
      mon_fire |=> perf == $past(err_cnt) && err_cnt <= 1 && done)
      else $error("update did not copy and restart the count");
   a_auto_hold: assert property (@(posedge clk_sys) disable iff (rst)
      (ctrl[`BERTC_CTRL_ARD] && chk == CHK_LOCK && !rx_ld_fire && !rs_fire)
      |=> chk == CHK_LOCK)
      else $error("checker left lock with auto resync disabled");
   a_auto_resync: assert property (@(posedge clk_sys) disable iff (rst)
      (bit_err && win_err == 3'h5 && win_cnt != 6'h3f && !ctrl[`BERTC_CTRL_ARD])
      |=> chk == CHK_HUNT)
      else $error("sixth window error did not resync");
   a_tx_invert: assert property (@(posedge clk_sys) disable iff (rst)
      tx_step |=> tx_data == ($past(tx_pred) ^ $past(ctrl[`BERTC_CTRL_TXINV])))
      else $error("transmit bit not inverted as programmed");
   a_rx_invert_err: assert property (@(posedge clk_sys) disable iff (rst)
      (rx_step && chk == CHK_LOCK && !mon_fire && err_cnt != {ERR_W{1'b1}}
       && ((ls_rx_bit ^ ctrl[`BERTC_CTRL_RXINV]) != rx_pred))
      |=> err_cnt == $past(err_cnt) + {{(ERR_W-1){1'b0}}, 1'b1})
      else $error("inverted receive mismatch not counted");
endmodule : bertc_top

//--- bertc_line_model.sv
// behavioural model of the serial line: free-running line clocks, receive stream, transmit capture
module bertc_line_model (
   // line clocks made by the far side
   output logic tx_line_clock,
   output logic rx_line_clock,
   // serial data
   output logic rx_data,
   input wire logic tx_data,
   // stream control from the bench
   input wire logic [31:0] word,
   input wire logic flip,
   // last 32 transmitted bits, newest in bit 0
   output logic [31:0] tx_cap
);
   timeunit 1ns;
   timeprecision 100ps;
   int idx = 31;
   // odd start offsets keep line edges away from the system clock edges
   initial
   begin
      tx_line_clock = 1'b0;
      #7;
      forever #40 tx_line_clock = ~tx_line_clock;
   end
   initial
   begin
      rx_line_clock = 1'b0;
      #13;
      forever #40 rx_line_clock = ~rx_line_clock;
   end
   // data changes on the falling edge so it is stable around each rising edge
   initial rx_data = 1'b0;
   always @(negedge rx_line_clock)
   begin
      rx_data <= word[idx] ^ flip;
      idx <= (idx == 0) ? 31 : idx - 1;
   end
   // transmitted bit is settled long before the next line clock rise
   initial tx_cap = 32'h00000000;
   always @(posedge tx_line_clock)
   begin
      tx_cap <= {tx_cap[30:0], tx_data};
   end
endmodule : bertc_line_model

//--- bertc_top_tb.sv
// self-checking bench for the bit error rate tester control block
`include "bertc_regs.svh"
module bertc_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import bertc_pkg::*;
   localparam logic [31:0] SEED = 32'h9a3c71e4;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   bertc_byte_t addr = 8'h00;
   bertc_byte_t wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   bertc_byte_t rdata;
   logic tx_line_clock;
   logic rx_line_clock;
   logic rx_data;
   logic tx_data;
   logic flip = 1'b0;
   logic [31:0] tx_cap;
   bertc_byte_t ctrl = 8'h00;
   int n_fail = 0;
   int num_checks = 0;

   bertc_top #(.ERR_W(32)) u_dut (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .tx_line_clock(tx_line_clock),
      .rx_line_clock(rx_line_clock), .rx_data(rx_data), .tx_data(tx_data));
   bertc_line_model u_line (.tx_line_clock(tx_line_clock), .rx_line_clock(rx_line_clock),
      .rx_data(rx_data), .tx_data(tx_data), .word(SEED), .flip(flip), .tx_cap(tx_cap));

   always #5 clk_sys = ~clk_sys;

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_of_test

   task automatic chk8(input string name, input bertc_byte_t exp, input bertc_byte_t got);
      num_checks++;
      if (got !== exp)
      begin
         $display("mismatch %s expected %h seen %h", name, exp, got);
         n_fail++;
      end
   endtask : chk8

   task automatic chk32(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp)
      begin
         $display("mismatch %s expected %h seen %h", name, exp, got);
         n_fail++;
      end
   endtask : chk32

   task automatic wr_reg(input bertc_byte_t a, input bertc_byte_t d);
      @(posedge clk_sys);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask : wr_reg

   // read data stands only in the cycle after the strobe
   task automatic rd_reg(input bertc_byte_t a, output bertc_byte_t d);
      @(posedge clk_sys);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd_reg

   task automatic set_ctrl(input bertc_byte_t v);
      bertc_byte_t d;
      ctrl = {1'b0, v[6:0]};
      wr_reg(`BERTC_OFF_CTRL, ctrl);
      rd_reg(`BERTC_OFF_CTRL, d);
      chk8("control", ctrl, d);
   endtask : set_ctrl

   task automatic wait_oos(input logic exp, input int lim);
      bertc_byte_t s;
      for (int i = 0; i < lim; i++)
      begin
         rd_reg(`BERTC_OFF_STATUS, s);
         if (s[0] === exp)
            break;
      end
      chk8("out of sync", {7'h00, exp}, {7'h00, s[0]});
   endtask : wait_oos

   task automatic t_regs;
      bertc_byte_t d;
      rd_reg(`BERTC_OFF_CTRL, d);
      chk8("control reset", 8'h00, d);
      rd_reg(`BERTC_OFF_CFG_LO, d);
      chk8("config low reset", 8'h00, d);
      rd_reg(`BERTC_OFF_STATUS, d);
      chk8("status reset", 8'h01, d);
      wr_reg(8'h81, 8'h55);
      rd_reg(8'h81, d);
      chk8("unmapped", 8'h00, d);
      wr_reg(`BERTC_OFF_CFG_LO, 8'hff);
      rd_reg(`BERTC_OFF_CFG_LO, d);
      chk8("config low", 8'h7f, d);
      wr_reg(`BERTC_OFF_CFG_HI, 8'hff);
      rd_reg(`BERTC_OFF_CFG_HI, d);
      chk8("config high", 8'h1f, d);
   endtask : t_regs

   // repetitive 32-bit pattern, tap field left at zero since it is ignored here
   task automatic set_pattern;
      wr_reg(`BERTC_OFF_CFG_LO, 8'h3f);
      wr_reg(`BERTC_OFF_CFG_HI, 8'h00);
      for (int i = 0; i < 4; i++)
         wr_reg(bertc_byte_t'(`BERTC_OFF_SEED0 + i), SEED[8*i +: 8]);
   endtask : set_pattern

   // the capture phase is unknown, so any rotation of the word is accepted
   task automatic chk_tx(input logic inv);
      logic [31:0] rot;
      logic [31:0] exp;
      exp = inv ? ~SEED : SEED;
      for (int r = 0; r < 32; r++)
      begin
         rot = (SEED << r) | (SEED >> (32 - r));
         if (tx_cap === (inv ? ~rot : rot))
            exp = tx_cap;
      end
      chk32("tx pattern", exp, tx_cap);
   endtask : chk_tx

   task automatic t_tx;
      set_ctrl(8'h02);
      repeat (64) @(posedge clk_sys);
      repeat (360) @(posedge clk_sys);
      chk_tx(1'b0);
      set_ctrl(8'h03);
      repeat (360) @(posedge clk_sys);
      chk_tx(1'b1);
      set_ctrl(8'h00);
   endtask : t_tx

   task automatic t_rx;
      set_ctrl(8'h20);
      repeat (64) @(posedge clk_sys);
      wait_oos(1'b0, 1000);
      set_ctrl(8'h00);
      set_ctrl(8'h20);
      wait_oos(1'b1, 20);
      wait_oos(1'b0, 1000);
      flip <= 1'b1;
      wait_oos(1'b1, 600);
      set_ctrl(8'h30);
      wait_oos(1'b0, 1000);
   endtask : t_rx

   task automatic t_hold;
      bertc_byte_t s;
      logic seen;
      seen = 1'b0;
      set_ctrl(8'h34);
      flip <= 1'b0;
      for (int i = 0; i < 300; i++)
      begin
         rd_reg(`BERTC_OFF_STATUS, s);
         seen = seen | s[0];
      end
      chk8("lock held", 8'h00, {7'h00, seen});
      set_ctrl(8'h74);
      for (int i = 0; i < 100; i++)
      begin
         rd_reg(`BERTC_OFF_STATUS, s);
         if (s[3] === 1'b1)
            break;
      end
      chk8("update done", 8'h08, s & 8'h08);
      rd_reg(`BERTC_OFF_ERR0, s);
      chk8("error count", 8'h01, {7'h00, s != 8'h00});
      set_ctrl(8'h34);
      rd_reg(`BERTC_OFF_STATUS, s);
      chk8("update done low", 8'h00, s & 8'h08);
      set_ctrl(8'h3c);
      wait_oos(1'b1, 20);
      flip <= 1'b1;
      wait_oos(1'b0, 1000);
   endtask : t_hold

   // pseudo-random transmit stream against a reference two-tap generator started from the seed
   task automatic t_prbs(input bertc_byte_t lo, input bertc_byte_t hi, input int n, input int y);
      logic [31:0] s;
      logic [31:0] w;
      logic b;
      logic hit;
      int zeros;
      s = SEED;
      w = 32'h00000000;
      hit = 1'b0;
      zeros = 0;
      wr_reg(`BERTC_OFF_CFG_LO, lo);
      wr_reg(`BERTC_OFF_CFG_HI, hi);
      set_ctrl(8'h00);
      set_ctrl(8'h02);
      repeat (424) @(posedge clk_sys);
      for (int i = 0; i < 120; i++)
      begin
         b = s[n-1] ^ s[y-1];
         if (lo[`BERTC_CFG_QUASI_RANDOM_SELECT] && zeros == 14)
            b = 1'b1;
         zeros = b ? 0 : zeros + 1;
         s = {s[30:0], b};
         w = {w[30:0], b};
         if (i >= 31 && w === tx_cap)
            hit = 1'b1;
      end
      chk8("prbs stream", 8'h01, {7'h00, hit});
   endtask : t_prbs

   initial
   begin
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      t_regs();
      set_pattern();
      t_tx();
      t_rx();
      t_hold();
      t_prbs(8'h0e, 8'h0d, 15, 14);
      t_prbs(8'h6e, 8'h0d, 20, 17);
      end_of_test();
   end

   // the sequence needs well under half of this span
   initial
   begin
      #900000;
      n_fail++;
      end_of_test();
   end
endmodule : bertc_top_tb
